// ---- verilog/ppm_core.sv ----
// What this block does
// (R01) Basic mode: four independently directed port sections
// (R02) Outputs latched, inputs passed through unlatched
// (R03) Flag-one control word picks sixteen directions
// (R04) Strobed mode per group, port C handshakes
// (R05) Strobe loads input latch; read presents it
// (R06) Input full: set on strobe fall, clear read rise
// (R07) Input irq: strobe rise with full and enable
// (R08) Input enables: A via bit 4, B bit 2
// (R09) Output full low on write rise, high ack fall
// (R10) Output irq: ack rise with enable; write clears
// (R11) Output enables: A via bit 6, B bit 2
// (R12) Strobed mode port C handshake bit map
// (R13) Unused port C bits stay basic I/O
// (R14) Bidirectional mode on port A, group A only
// (R15) Bidir write loads latch, port A stays released
// (R16) Bidir ack low drives port A, releases output full
// (R17) Bidir strobe loads separate input latch
// (R18) Bidir input full: strobe fall, read rise
// (R19) Bidir has two enables: bits 6 and 4
// (R20) Port C set/reset writes the enable flops
// (R21) Bidir port C map: bits 3 to 7
// (R22) Mode-changing control write clears A, C latches
// (R23) Host selects register by address, cs, rd/wr
// (R24) Control word field layout, one means input
// (R25) Irq is pending condition AND enable
`default_nettype none
module ppm_core
  import ppm_pkg::*;
(
  // Clocking
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Host bus (same clock domain)
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       port_sel_hi,
  input  wire logic       port_sel_lo,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            rdata_oe_n,
  // Port A pins
  input  wire logic [7:0] pa_in,
  output logic      [7:0] pa_out,
  output logic      [7:0] pa_oe_n,
  // Port B pins
  input  wire logic [7:0] pb_in,
  output logic      [7:0] pb_out,
  output logic      [7:0] pb_oe_n,
  // Port C pins
  input  wire logic [7:0] pc_in,
  output logic      [7:0] pc_out,
  output logic      [7:0] pc_oe_n,
  // Handshake status for observation
  output logic            grp_a_irq,
  output logic            grp_b_irq
);
  // Whole module state
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] lat_a;
    logic [7:0] lat_b;
    logic [7:0] lat_c;
    logic [7:0] in_a;
    logic [7:0] in_b;
    ppm_hs_s    hs_a;
    ppm_hs_s    hs_b;
    logic       rd_d1;
    logic       wr_d1;
    logic [7:0] rdata;
    logic       rdata_oe_n;
    logic [7:0] pa_out;
    logic [7:0] pa_oe_n;
    logic [7:0] pb_out;
    logic [7:0] pb_oe_n;
    logic [7:0] pc_out;
    logic [7:0] pc_oe_n;
    logic       irq_a;
    logic       irq_b;
  } ppm_state_s;

  ppm_state_s st_q;
  ppm_state_s st_d;

  // Pins cross into the clock domain first
  logic [7:0] pa_s;
  logic [7:0] pb_s;
  logic [7:0] pc_s;
  logic [3:0] hs_rise;
  logic [3:0] hs_fall;

  ppm_sync #(.W(24)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({pa_in, pb_in, pc_in}),
    .q     ({pa_s, pb_s, pc_s})
  );

  // Edges of A strobe, A ack, B strobe/ack, spare
  ppm_edge #(.W(4)) u_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .lvl   ({1'b1, pc_s[PC_B_HS], pc_s[PC_A_ACK], pc_s[PC_A_STB]}),
    .rise  (hs_rise),
    .fall  (hs_fall)
  );

  // Group A mode from the control word; 1x means bidirectional
  function automatic ppm_mode_e mode_a(input logic [7:0] cw);
    if (cw[CW_AMODE_H])
      return PPM_MODE_BIDIR;
    else if (cw[CW_AMODE_L])
      return PPM_MODE_STROBE;
    else
      return PPM_MODE_BASIC;
  endfunction : mode_a

  // Mask of port C bits taken by handshakes
  function automatic logic [7:0] hs_mask(input logic [7:0] cw);
    logic [7:0] m;
    m = 8'h00;
    if (mode_a(cw) == PPM_MODE_BIDIR)
      m = 8'hF8; // R21
    else if (mode_a(cw) == PPM_MODE_STROBE)
      m = cw[CW_A_DIR] ? 8'h38 : 8'hC8; // R12
    if (cw[CW_BMODE])
      m = m | 8'h07; // R12
    return m;
  endfunction : hs_mask

  logic       rd_act;
  logic       wr_act;
  logic       rd_rise;
  logic       wr_rise;
  logic       rd_fall;
  logic       wr_fall;
  ppm_mode_e  ma;
  logic       mb;
  logic       a_in;
  logic       b_in;
  logic [7:0] cdir_in;
  logic [7:0] hmask;
  logic [2:0] bsel;
  logic [7:0] hs_val;
  logic       a_ack_low;

  always_comb
  begin
    st_d      = st_q;
    rd_act    = !cs_n && !rd_n; // R23
    wr_act    = !cs_n && !wr_n; // R23
    rd_fall   = rd_act && !st_q.rd_d1;
    rd_rise   = !rd_act && st_q.rd_d1;
    wr_fall   = wr_act && !st_q.wr_d1;
    wr_rise   = !wr_act && st_q.wr_d1;
    st_d.rd_d1 = rd_act;
    st_d.wr_d1 = wr_act;
    ma        = mode_a(st_q.ctrl);
    mb        = st_q.ctrl[CW_BMODE];
    a_in      = st_q.ctrl[CW_A_DIR]; // R24
    b_in      = st_q.ctrl[CW_B_DIR]; // R24
    cdir_in   = {{4{st_q.ctrl[CW_CU_DIR]}}, {4{st_q.ctrl[CW_CL_DIR]}}}; // R01
    hmask     = hs_mask(st_q.ctrl);
    bsel      = wdata[BSR_SEL_H:BSR_SEL_L];
    a_ack_low = !pc_s[PC_A_ACK];

    // Write on rising edge of the write strobe
    if (wr_rise)
    begin
      case ({port_sel_hi, port_sel_lo})
        ADDR_PORT_A:
        begin
          st_d.lat_a = wdata; // R02
          if (ma != PPM_MODE_BASIC && (ma == PPM_MODE_BIDIR || !a_in))
            st_d.hs_a.out_full_n = 1'b0; // R09 R15
        end
        ADDR_PORT_B:
        begin
          st_d.lat_b = wdata; // R02
          if (mb && !b_in)
            st_d.hs_b.out_full_n = 1'b0; // R09
        end
        ADDR_PORT_C:
          st_d.lat_c = (st_q.lat_c & hmask) | (wdata & ~hmask); // R13
        ADDR_CTRL:
        begin
          if (wdata[CW_FLAG])
          begin
            // R03
            st_d.ctrl = wdata;
            if (wdata != st_q.ctrl)
            begin
              st_d.lat_a = BYTE_ZERO; // R22
              st_d.lat_c = BYTE_ZERO; // R22
              st_d.hs_a  = '{in_full: 1'b0, out_full_n: 1'b1,
                             ien_in: 1'b0, ien_out: 1'b0};
              st_d.hs_b  = '{in_full: 1'b0, out_full_n: 1'b1,
                             ien_in: 1'b0, ien_out: 1'b0};
            end
          end
          else
          begin
            // Single-bit set/reset; also steers enables
            st_d.lat_c[bsel] = wdata[BSR_VAL];
            if (bsel == 3'(PC_A_STB))
              st_d.hs_a.ien_in = wdata[BSR_VAL]; // R08 R19 R20
            if (bsel == 3'(PC_A_ACK))
              st_d.hs_a.ien_out = wdata[BSR_VAL]; // R11 R19 R20
            if (bsel == 3'(PC_B_HS))
            begin
              st_d.hs_b.ien_in  = wdata[BSR_VAL]; // R08 R20
              st_d.hs_b.ien_out = wdata[BSR_VAL]; // R11 R20
            end
          end
        end
        default: ;
      endcase
    end

    // Read of port A or B ends transfer on rising read edge
    if (rd_rise && {port_sel_hi, port_sel_lo} == ADDR_PORT_A
        && ma != PPM_MODE_BASIC)
      st_d.hs_a.in_full = 1'b0; // R06 R18
    if (rd_rise && {port_sel_hi, port_sel_lo} == ADDR_PORT_B && mb)
      st_d.hs_b.in_full = 1'b0; // R06

    // Strobe falling loads latch; set wins over read clear
    if (hs_fall[0] && (ma == PPM_MODE_BIDIR || (ma == PPM_MODE_STROBE && a_in)))
    begin
      st_d.in_a         = pa_s; // R05 R17
      st_d.hs_a.in_full = 1'b1; // R06 R18
    end
    if (hs_fall[2] && mb && b_in)
    begin
      st_d.in_b         = pb_s; // R05
      st_d.hs_b.in_full = 1'b1; // R06
    end

    // Ack falling empties the output side; beats a write
    if (hs_fall[1] && (ma == PPM_MODE_BIDIR || (ma == PPM_MODE_STROBE && !a_in)))
      st_d.hs_a.out_full_n = 1'b1; // R09 R16
    if (hs_fall[2] && mb && !b_in)
      st_d.hs_b.out_full_n = 1'b1; // R09

    // Interrupt: pending and enabled; a new event wins over a host clear
    if (ma == PPM_MODE_BASIC)
      st_d.irq_a = 1'b0;
    else if (hs_rise[0] && st_q.hs_a.in_full && st_q.hs_a.ien_in
             && (ma == PPM_MODE_BIDIR || a_in))
      st_d.irq_a = 1'b1; // R07 R25
    else if (hs_rise[1] && st_q.hs_a.out_full_n && st_q.hs_a.ien_out
             && (ma == PPM_MODE_BIDIR || !a_in))
      st_d.irq_a = 1'b1; // R10 R25
    else if ((rd_fall && {port_sel_hi, port_sel_lo} == ADDR_PORT_A)
             || (wr_fall && {port_sel_hi, port_sel_lo} == ADDR_PORT_A))
      st_d.irq_a = 1'b0; // R07 R10
    else if (!(st_q.hs_a.ien_in && st_q.hs_a.in_full)
             && !(st_q.hs_a.ien_out && st_q.hs_a.out_full_n))
      st_d.irq_a = 1'b0; // R25

    if (!mb)
      st_d.irq_b = 1'b0;
    else if (hs_rise[2] && (b_in ? st_q.hs_b.in_full && st_q.hs_b.ien_in
                                 : st_q.hs_b.out_full_n && st_q.hs_b.ien_out))
      st_d.irq_b = 1'b1; // R07 R10 R25
    else if ((rd_fall || wr_fall) && {port_sel_hi, port_sel_lo} == ADDR_PORT_B)
      st_d.irq_b = 1'b0; // R07 R10
    else if (!(b_in ? st_q.hs_b.ien_in && st_q.hs_b.in_full
                    : st_q.hs_b.ien_out && st_q.hs_b.out_full_n))
      st_d.irq_b = 1'b0; // R25

    // Port A drive: basic by direction, bidir only under ack
    st_d.pa_out = st_q.lat_a;
    case (ma)
      PPM_MODE_BIDIR:  st_d.pa_oe_n = {8{!a_ack_low}}; // R14 R15 R16
      PPM_MODE_STROBE: st_d.pa_oe_n = {8{a_in}}; // R04
      PPM_MODE_BASIC:  st_d.pa_oe_n = {8{a_in}}; // R01
      default:         st_d.pa_oe_n = 8'hFF;
    endcase
    st_d.pb_out  = st_q.lat_b;
    st_d.pb_oe_n = {8{b_in}}; // R01 R04

    // Port C: handshake outputs from next state, in step with irq pins
    hs_val = st_q.lat_c;
    hs_val[PC_A_IRQ] = st_d.irq_a;
    hs_val[PC_A_IBF] = st_d.hs_a.in_full;
    hs_val[PC_A_OBF] = st_d.hs_a.out_full_n;
    hs_val[PC_B_IRQ] = st_d.irq_b;
    hs_val[PC_B_FULL] = b_in ? st_d.hs_b.in_full : st_d.hs_b.out_full_n;
    st_d.pc_out = (hs_val & hmask) | (st_q.lat_c & ~hmask); // R12 R21
    // Strobe/ack inputs released; other handshakes driven
    st_d.pc_oe_n = (cdir_in & ~hmask)
                 | (hmask & 8'h54 & {8'hFF}); // R13
    if (!(|(hmask & 8'h04)))
      st_d.pc_oe_n[PC_B_HS] = cdir_in[PC_B_HS];

    // Read path: inputs unlatched in basic mode
    st_d.rdata_oe_n = !rd_act;
    case ({port_sel_hi, port_sel_lo})
      ADDR_PORT_A: st_d.rdata = (ma == PPM_MODE_BASIC)
                              ? (a_in ? pa_s : st_q.lat_a) : st_q.in_a; // R02 R17
      ADDR_PORT_B: st_d.rdata = !mb ? (b_in ? pb_s : st_q.lat_b)
                              : (b_in ? st_q.in_b : st_q.lat_b); // R02 R05
      ADDR_PORT_C: st_d.rdata = (pc_s & cdir_in & ~hmask)
                              | (st_q.pc_out & ~(cdir_in & ~hmask));
      default:     st_d.rdata = BYTE_ZERO;
    endcase
  end

  // Single state register, frozen while clock enable is low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q            <= '0;
      st_q.ctrl       <= CW_RESET;
      st_q.hs_a       <= 4'b0100;
      st_q.hs_b       <= 4'b0100;
      st_q.rdata_oe_n <= 1'b1;
      st_q.pa_oe_n    <= 8'hFF;
      st_q.pb_oe_n    <= 8'hFF;
      st_q.pc_oe_n    <= 8'hFF;
    end
    else if (ce)
      st_q <= st_d;
  end

  // All outputs straight from the state register
  assign rdata      = st_q.rdata;
  assign rdata_oe_n = st_q.rdata_oe_n;
  assign pa_out     = st_q.pa_out;
  assign pa_oe_n    = st_q.pa_oe_n;
  assign pb_out     = st_q.pb_out;
  assign pb_oe_n    = st_q.pb_oe_n;
  assign pc_out     = st_q.pc_out;
  assign pc_oe_n    = st_q.pc_oe_n;
  assign grp_a_irq  = st_q.irq_a;
  assign grp_b_irq  = st_q.irq_b;
endmodule : ppm_core
`default_nettype wire

// ---- verilog/ppm_pkg.sv ----
`default_nettype none
package ppm_pkg;
  // Host address decode (two select lines)
  localparam logic [1:0] ADDR_PORT_A = 2'h0;
  localparam logic [1:0] ADDR_PORT_B = 2'h1;
  localparam logic [1:0] ADDR_PORT_C = 2'h2;
  localparam logic [1:0] ADDR_CTRL   = 2'h3;

  // Control word field positions
  localparam int CW_FLAG    = 7;
  localparam int CW_AMODE_H = 6;
  localparam int CW_AMODE_L = 5;
  localparam int CW_A_DIR   = 4;
  localparam int CW_CU_DIR  = 3;
  localparam int CW_BMODE   = 2;
  localparam int CW_B_DIR   = 1;
  localparam int CW_CL_DIR  = 0;

  // Bit set/reset word fields
  localparam int BSR_SEL_H = 3;
  localparam int BSR_SEL_L = 1;
  localparam int BSR_VAL   = 0;

  // Port C handshake bit positions
  localparam int PC_B_IRQ  = 0;
  localparam int PC_B_FULL = 1;
  localparam int PC_B_HS   = 2;
  localparam int PC_A_IRQ  = 3;
  localparam int PC_A_STB  = 4;
  localparam int PC_A_IBF  = 5;
  localparam int PC_A_ACK  = 6;
  localparam int PC_A_OBF  = 7;

  // Reset values: all ports input, mode 0
  localparam logic [7:0] CW_RESET = 8'h9B;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Group A operating modes
  typedef enum logic [1:0] {
    PPM_MODE_BASIC  = 2'b00,
    PPM_MODE_STROBE = 2'b01,
    PPM_MODE_BIDIR  = 2'b10
  } ppm_mode_e;

  // Host bus request bundle
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [1:0] addr;
    logic [7:0] wdata;
  } ppm_host_s;

  // Per-group handshake state
  typedef struct packed {
    logic in_full;
    logic out_full_n;
    logic ien_in;
    logic ien_out;
  } ppm_hs_s;
endpackage : ppm_pkg
`default_nettype wire

// ---- verilog/ppm_sync.sv ----
`default_nettype none
module ppm_sync
  import ppm_pkg::*;
#(
  parameter int W = 8
) (
  // Clocking
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppm_sync_s;

  ppm_sync_s st_q;
  ppm_sync_s st_d;

  // Two-stage chain; only stage two is visible
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '0;
    else if (ce)
      st_q <= st_d;
  end

  assign q = st_q.s2;
endmodule : ppm_sync
`default_nettype wire

// ---- verilog/ppm_edge.sv ----
`default_nettype none
module ppm_edge
  import ppm_pkg::*;
#(
  parameter int W = 4
) (
  // Clocking
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Synchronised levels in, edge pulses out
  input  wire logic [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] prev;
  } ppm_edge_s;

  ppm_edge_s st_q;
  ppm_edge_s st_d;

  always_comb
  begin
    st_d      = st_q;
    st_d.prev = lvl;
  end

  // Idle-high reset; the synchroniser resets low, so a released strobe gives a fall, then a rise, after reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= '1;
    else if (ce)
      st_q <= st_d;
  end

  assign rise = lvl & ~st_q.prev;
  assign fall = ~lvl & st_q.prev;
endmodule : ppm_edge
`default_nettype wire

// ---- sim/ppm_props.sv ----
`default_nettype none
module ppm_props
  import ppm_pkg::*;
(
  // Clocking
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       ce,
  // Host
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       port_sel_hi,
  input wire logic       port_sel_lo,
  input wire logic [7:0] wdata,
  input wire logic       rdata_oe_n,
  // Pins
  input wire logic [7:0] pa_oe_n,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe_n,
  input wire logic [7:0] pc_in,
  input wire logic [7:0] pc_out,
  input wire logic [7:0] pc_oe_n,
  input wire logic       grp_a_irq,
  input wire logic       grp_b_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Group A mode seen from port C drive pattern; no access to the control word
  wire logic sin_a  = pc_oe_n[4] && !pc_oe_n[5];
  wire logic sout_a = pc_oe_n[6] && !pc_oe_n[7];
  wire logic [1:0] sel = {port_sel_hi, port_sel_lo};

  a_read_drive: assert property (ce && !cs_n && !rd_n |=> !rdata_oe_n)
    else $error("read bus not driven");
  a_irq_a_pin: assert property (grp_a_irq |-> pc_out[3] && !pc_oe_n[3])
    else $error("group A irq missing on port C");
  a_irq_b_pin: assert property (grp_b_irq |-> pc_out[0] && !pc_oe_n[0])
    else $error("group B irq missing on port C");
  a_pa_dir_whole: assert property (pa_oe_n == 8'h00 || pa_oe_n == 8'hFF)
    else $error("port A direction split");
  a_pb_dir_whole: assert property (pb_oe_n == 8'h00 || pb_oe_n == 8'hFF)
    else $error("port B direction split");
  a_in_full_set: assert property (ce && sin_a && $fell(pc_in[4]) |-> ##[1:6] pc_out[5])
    else $error("input full not set by strobe");
  a_out_full_ack: assert property (ce && sout_a && $fell(pc_in[6]) |-> ##[1:6] pc_out[7])
    else $error("output full not released by ack");
  a_ack_drives_a: assert property (ce && sin_a && sout_a && $fell(pc_in[6])
    |-> ##[1:6] pa_oe_n == 8'h00)
    else $error("ack did not drive port A");
  a_wr_full_low: assert property (ce && sout_a && $rose(wr_n) && !cs_n
    && sel == ADDR_PORT_A |=> !pc_out[7])
    else $error("write did not mark output full");
  a_b_latch: assert property (ce && pb_oe_n == 8'h00 && $rose(wr_n) && !cs_n
    && sel == ADDR_PORT_B |=> ##1 pb_out == $past(wdata, 2))
    else $error("port B latch wrong");
endmodule : ppm_props

bind ppm_core ppm_props props_u (.clk, .rst_n, .ce, .cs_n, .rd_n, .wr_n, .port_sel_hi,
  .port_sel_lo, .wdata, .rdata_oe_n, .pa_oe_n, .pb_out, .pb_oe_n, .pc_in, .pc_out,
  .pc_oe_n, .grp_a_irq, .grp_b_irq);
`default_nettype wire

// ---- sim/ppm_periph.sv ----
`default_nettype none
module ppm_periph
(
  // Clocking
  input  wire logic       clk,
  // Device drive
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe_n,
  input  wire logic [7:0] pb_out,
  input  wire logic [7:0] pb_oe_n,
  input  wire logic [7:0] pc_out,
  input  wire logic [7:0] pc_oe_n,
  // Pin levels
  output logic      [7:0] pa_in,
  output logic      [7:0] pb_in,
  output logic      [7:0] pc_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] va, vb, tog;
  logic       da, db;
  logic [2:0] hs; // Ack A, strobe A, strobe B levels

  initial
  begin
    va = 8'h00;
    vb = 8'h00;
    tog = 8'h5A;
    da = 1'b0;
    db = 1'b0;
    hs = 3'b111;
  end
  // Released lines toggle so a stale value is never mistaken for data
  always @(posedge clk) tog <= ~tog;
  assign pa_in = (~pa_oe_n & pa_out) | (pa_oe_n & (da ? va : tog));
  assign pb_in = (~pb_oe_n & pb_out) | (pb_oe_n & (db ? vb : tog));
  assign pc_in = (~pc_oe_n & pc_out)
    | (pc_oe_n & {tog[7], hs[2], tog[5], hs[1], tog[3], hs[0], tog[1:0]});

  // Low pulse of 8 cycles: k 0 strobe B, 1 strobe A, 2 ack A; data held past it
  task automatic pulse(input int k, input logic [7:0] d);
    @(negedge clk);
    va = d;
    vb = d;
    da = (k == 1);
    db = (k == 0);
    hs[k] = 1'b0;
    repeat (8) @(negedge clk);
    hs[k] = 1'b1;
    repeat (3) @(negedge clk);
    da = 1'b0;
    db = 1'b0;
    repeat (5) @(negedge clk);
  endtask : pulse
endmodule : ppm_periph
`default_nettype wire

// ---- sim/tb.sv ----
`default_nettype none
module tb;
  import ppm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk, rst_n, cs_n, rd_n, wr_n, roe, ia, ib;
  logic [1:0] a;
  logic [7:0] wdata, rdata, pa_in, pa_out, pa_oe_n, pb_in, pb_out, pb_oe_n;
  logic [7:0] pc_in, pc_out, pc_oe_n, cw, d, g;
  int         n_errors, check_count, cyc;

  ppm_core dut_u (.clk, .rst_n, .ce(1'b1), .cs_n, .rd_n, .wr_n, .port_sel_hi(a[1]),
    .port_sel_lo(a[0]), .wdata, .rdata, .rdata_oe_n(roe), .pa_in, .pa_out, .pa_oe_n,
    .pb_in, .pb_out, .pb_oe_n, .pc_in, .pc_out, .pc_oe_n, .grp_a_irq(ia), .grp_b_irq(ib));
  ppm_periph per_u (.clk, .pa_out, .pa_oe_n, .pb_out, .pb_oe_n, .pc_out, .pc_oe_n,
    .pa_in, .pb_in, .pc_in);

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
    check_count++;
    if (v !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, v);
    end
  endtask : chk

  // Host write; cs held past the write rise so the address is still valid
  task automatic wr(input logic [1:0] ad, input logic [7:0] dv);
    @(negedge clk);
    cs_n = 1'b0;
    a = ad;
    wdata = dv;
    wr_n = 1'b0;
    @(negedge clk);
    wr_n = 1'b1;
    @(negedge clk);
    cs_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : wr

  // Host read; waits out the pin synchroniser before sampling
  task automatic rd(input logic [1:0] ad, output logic [7:0] dv);
    @(negedge clk);
    cs_n = 1'b0;
    a = ad;
    rd_n = 1'b0;
    repeat (4) @(negedge clk);
    dv = rdata;
    rd_n = 1'b1;
    @(negedge clk);
    cs_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : rd

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end

  initial
  begin
    {rst_n, cs_n, rd_n, wr_n, a, wdata} = {4'h7, 2'h0, 8'h00};
    void'($urandom(32'hD5805036));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    chk("rst_oe", 8'hFF, pa_oe_n & pb_oe_n & pc_oe_n);
    chk("rst_irq", 8'h00, {6'h00, ia, ib});
    // All sixteen basic direction words, random data each
    for (int i = 0; i < 16; i++)
    begin
      cw = {3'b100, i[3], i[2], 1'b0, i[1], i[0]};
      wr(ADDR_CTRL, cw);
      chk("oe_a", {8{cw[4]}}, pa_oe_n);
      chk("oe_b", {8{cw[1]}}, pb_oe_n);
      chk("oe_c", {{4{cw[3]}}, {4{cw[0]}}}, pc_oe_n);
      chk("clr_ac", 8'h00, pa_out | pc_out);
      d = 8'($urandom);
      wr(ADDR_PORT_A, d);
      wr(ADDR_PORT_B, d ^ 8'h3C);
      per_u.va = ~d;
      per_u.vb = d;
      per_u.da = 1'b1;
      per_u.db = 1'b1;
      rd(ADDR_PORT_A, g);
      chk("rd_a", cw[4] ? ~d : d, g);
      rd(ADDR_PORT_B, g);
      chk("rd_b", cw[1] ? d : d ^ 8'h3C, g);
      wr(ADDR_CTRL, {4'h0, i[2:0], 1'b1});
      if (!(i[2] ? cw[3] : cw[0]))
        chk("bsr", 8'h01, {7'h00, pc_out[i[2:0]]});
    end
    // Group A strobed input: enable on, then off
    wr(ADDR_CTRL, 8'hB0);
    wr(ADDR_CTRL, 8'h09);
    d = 8'($urandom);
    per_u.pulse(1, d);
    chk("hs_a", 8'h07, {5'h00, pc_out[5], pc_out[3], ia});
    wr(ADDR_CTRL, 8'h0F);
    chk("free_c7", 8'h01, {7'h00, pc_out[7]});
    rd(ADDR_PORT_A, g);
    chk("rd_sa", d, g);
    chk("clr_a", 8'h00, {6'h00, pc_out[5], ia});
    wr(ADDR_CTRL, 8'h08);
    per_u.pulse(1, ~d);
    chk("no_irq", 8'h02, {6'h00, pc_out[5], ia});
    rd(ADDR_PORT_A, g);
    // Group A strobed output
    wr(ADDR_CTRL, 8'hA0);
    wr(ADDR_CTRL, 8'h0D);
    wr(ADDR_PORT_A, d);
    chk("out_a", d, pa_out);
    chk("obf_lo", 8'h00, {6'h00, pc_out[7], ia});
    per_u.pulse(2, 8'h00);
    chk("ack_a", 8'h03, {6'h00, pc_out[7], ia});
    wr(ADDR_PORT_A, ~d);
    chk("wr_clr", 8'h00, {6'h00, pc_out[7], ia});
    // Group B strobed input
    wr(ADDR_CTRL, 8'h86);
    wr(ADDR_CTRL, 8'h05);
    per_u.pulse(0, d);
    chk("hs_b", 8'h07, {5'h00, pc_out[1], pc_out[0], ib});
    rd(ADDR_PORT_B, g);
    chk("rd_sb", d, g);
    chk("clr_b", 8'h00, {6'h00, pc_out[1], ib});
    // Bidirectional port A
    wr(ADDR_CTRL, 8'hC0);
    wr(ADDR_CTRL, 8'h09);
    wr(ADDR_CTRL, 8'h0D);
    wr(ADDR_PORT_A, d);
    chk("bd_hiz", 8'hFF, pa_oe_n);
    chk("bd_obf", 8'h00, {7'h00, pc_out[7]});
    per_u.pulse(2, 8'h00);
    chk("bd_rel", 8'hFF, pa_oe_n);
    chk("bd_ack", 8'h03, {6'h00, pc_out[7], ia});
    d = 8'($urandom);
    per_u.pulse(1, d);
    chk("bd_ibf", 8'h01, {7'h00, pc_out[5]});
    rd(ADDR_PORT_A, g);
    chk("bd_rd", d, g);
    chk("bd_clr", 8'h00, {7'h00, pc_out[5]});
    complete_run();
  end
endmodule : tb
`default_nettype wire
